// >>> shared/bamds_params.svh
`ifndef BAMDS_PARAMS_SVH
`define BAMDS_PARAMS_SVH

// Condition flag bit positions
`define BAMDS_FLAG_H     5
`define BAMDS_FLAG_N     3
`define BAMDS_FLAG_Z     2
`define BAMDS_FLAG_V     1
`define BAMDS_FLAG_C     0

// Reset values
`define BAMDS_RESULT_RST 16'h0000
`define BAMDS_FLAGS_RST  8'h00

// Divide iterations, one quotient bit each
`define BAMDS_DIV_STEPS  4'h8

// Decimal adjust constants
`define BAMDS_BCD_LIMIT  4'h9
`define BAMDS_BCD_LO_ADJ 8'h06
`define BAMDS_BCD_HI_ADJ 8'h60
`define BAMDS_BCD_MAX    8'h99

`endif

// >>> shared/bamds_pkg.sv
package bamds_pkg;

    typedef enum logic [4:0] {
        BAMDS_OP_DECIMAL_ADJUST_ADD = 5'b00000,
        BAMDS_OP_DECIMAL_ADJUST_SUB = 5'b00001,
        BAMDS_OP_UNSIGNED_MULTIPLY  = 5'b00010,
        BAMDS_OP_UNSIGNED_DIVIDE    = 5'b00011,
        BAMDS_OP_COMPARE_OP         = 5'b00100,
        BAMDS_OP_TWOS_COMPLEMENT_OP = 5'b00101,
        BAMDS_OP_AND                = 5'b00110,
        BAMDS_OP_OR                 = 5'b00111,
        BAMDS_OP_XOR                = 5'b01000,
        BAMDS_OP_NOT                = 5'b01001,
        BAMDS_OP_ARITH_SHIFT_LEFT   = 5'b01010,
        BAMDS_OP_ARITH_SHIFT_RIGHT  = 5'b01011,
        BAMDS_OP_LOGIC_SHIFT_LEFT   = 5'b01100,
        BAMDS_OP_LOGIC_SHIFT_RIGHT  = 5'b01101,
        BAMDS_OP_ROTATE_LEFT        = 5'b01110,
        BAMDS_OP_ROTATE_RIGHT       = 5'b01111,
        BAMDS_OP_ROTATE_LEFT_CARRY  = 5'b10000,
        BAMDS_OP_ROTATE_RIGHT_CARRY = 5'b10001
    } bamds_op_t;

    typedef enum logic [1:0] {
        BAMDS_ST_IDLE = 2'b00,
        BAMDS_ST_DIV  = 2'b01
    } bamds_state_t;

endpackage : bamds_pkg

// >>> test/bamds_alu_sva.sv
`timescale 1ns/1ps
module bamds_alu_sva (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Request
    input wire logic                 start,
    input wire bamds_pkg::bamds_op_t op,
    input wire logic                 word_size,
    input wire logic                 use_imm,
    input wire logic [15:0]          rd_val,
    input wire logic [15:0]          rs_val,
    input wire logic [7:0]           flags_in,
    // Answer
    input wire logic [15:0]          result,
    input wire logic                 result_wr,
    input wire logic                 result_word,
    input wire logic [7:0]           condition_flags,
    input wire logic                 flags_wr,
    input wire logic                 op_error,
    input wire logic                 busy,
    input wire logic                 done
);
    import bamds_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic        take;
    logic [15:0] dv_rd_reg;
    logic [7:0]  dv_rs_reg;
    assign take = start && !busy;
    // Operands held so the answer ten cycles on can be judged
    always_ff @(posedge clk) begin
        if (take && op == BAMDS_OP_UNSIGNED_DIVIDE) begin
            dv_rd_reg <= rd_val;
            dv_rs_reg <= rs_val[7:0];
        end
    end
    mul_product_a: assert property (
        take && op == BAMDS_OP_UNSIGNED_MULTIPLY |=> result_wr && result_word
        && result == {8'h00, $past(rd_val[7:0])} * {8'h00, $past(rs_val[7:0])})
        else $error("product wrong");
    div_latency_a: assert property (
        take && op == BAMDS_OP_UNSIGNED_DIVIDE && rs_val[7:0] != 8'h00
        |=> busy [*8] ##1 busy ##1 (done && !busy && result_wr && result_word))
        else $error("divide timing wrong");
    div_zero_a: assert property (
        take && op == BAMDS_OP_UNSIGNED_DIVIDE && rs_val[7:0] == 8'h00
        |=> done && !result_wr) else $error("divide by zero wrote");
    div_split_a: assert property (
        take && op == BAMDS_OP_UNSIGNED_DIVIDE && rd_val[15:8] < rs_val[7:0]
        |-> ##10 result == {8'(dv_rd_reg % dv_rs_reg), 8'(dv_rd_reg / dv_rs_reg)})
        else $error("quotient placement wrong");
    cmp_flags_only_a: assert property (
        take && op == BAMDS_OP_COMPARE_OP && !(word_size && use_imm)
        |=> done && flags_wr && !result_wr) else $error("compare wrote result");
    word_imm_refused_a: assert property (
        take && op == BAMDS_OP_COMPARE_OP && word_size && use_imm
        |=> done && op_error && !flags_wr && !result_wr)
        else $error("word immediate compare taken");
    not_invert_a: assert property (
        take && op == BAMDS_OP_NOT
        |=> result_wr && result == {$past(rd_val[15:8]), ~$past(rd_val[7:0])})
        else $error("invert wrong");
    rotate_wrap_a: assert property (
        take && op == BAMDS_OP_ROTATE_LEFT
        |=> result[7:0] == {$past(rd_val[6:0]), $past(rd_val[7])}
        && condition_flags[0] == $past(rd_val[7]))
        else $error("rotate left wrong");
    carry_rotate_a: assert property (
        take && op == BAMDS_OP_ROTATE_RIGHT_CARRY
        |=> result[7:0] == {$past(flags_in[0]), $past(rd_val[7:1])}
        && condition_flags[0] == $past(rd_val[0]))
        else $error("rotate through carry wrong");
    cover property (take && op == BAMDS_OP_UNSIGNED_DIVIDE ##10 done);
    cover property (op_error);
    cover property (take && op == BAMDS_OP_ARITH_SHIFT_RIGHT ##1 done);
endmodule : bamds_alu_sva

bind bamds_alu bamds_alu_sva u_sva (.clk(clk), .rst(rst), .start(start), .op(op),
    .word_size(word_size), .use_imm(use_imm), .rd_val(rd_val), .rs_val(rs_val),
    .flags_in(flags_in), .result(result), .result_wr(result_wr), .result_word(result_word),
    .condition_flags(condition_flags), .flags_wr(flags_wr), .op_error(op_error),
    .busy(busy), .done(done));

// >>> test/tb_byte_alu_mul_div_shift.sv
`timescale 1ns/1ps
module tb_byte_alu_mul_div_shift;
    import bamds_pkg::*;
    logic        clk, rst, start, word_size, use_imm, result_wr, result_word;
    logic        flags_wr, op_error, busy, done, e_rw, e_wd, e_fw, e_err;
    bamds_op_t   op;
    logic [15:0] rd_val, rs_val, result, e_res;
    logic [7:0]  imm_val, flags_in, condition_flags, e_fl, fm;
    int          num_errors = 0;
    int          n_compared = 0;
    int          seed = 62602;
    bamds_alu dut (.clk(clk), .rst(rst), .start(start), .op(op), .word_size(word_size),
        .use_imm(use_imm), .rd_val(rd_val), .rs_val(rs_val), .imm_val(imm_val),
        .flags_in(flags_in), .result(result), .result_wr(result_wr),
        .result_word(result_word), .condition_flags(condition_flags),
        .flags_wr(flags_wr), .op_error(op_error), .busy(busy), .done(done));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // Reference model; H is masked on subtraction since its word form is open
    task automatic model(input logic [4:0] o);
        int a, b, r, c, v, w;
        a = rd_val[7:0];
        b = use_imm ? imm_val : rs_val[7:0];
        c = flags_in[0];
        v = 0;
        w = 8;
        r = a;
        e_res = rd_val;
        e_fl = flags_in;
        fm = 8'hFF;
        {e_rw, e_wd, e_fw, e_err} = 4'hE;
        case (o)
            5'h00: begin
                if (flags_in[5] || a % 16 > 9) r += 6;
                if (c || a > 153) begin
                    r += 96;
                    c = 1;
                end
            end
            5'h01: r = a - (flags_in[5] ? 6 : 0) - (c ? 96 : 0);
            5'h02: begin
                e_res = a * rs_val[7:0];
                e_fw = 0;
            end
            5'h03: if (rs_val[7:0] == 0) begin
                e_rw = 0;
                e_fl[2] = 1;
            end else begin
                e_res = {8'(rd_val % rs_val[7:0]), 8'(rd_val / rs_val[7:0])};
                e_fl[3] = e_res[7];
                e_fl[2] = 0;
            end
            5'h04, 5'h05: begin
                e_rw = (o == 5'h05);
                fm = 8'hDF;
                if (o == 5'h05) begin
                    b = a;
                    a = 0;
                end else if (word_size) begin
                    w = 16;
                    a = rd_val;
                    b = rs_val;
                end
                r = a - b;
                c = a < b;
                v = (((a ^ b) & (a ^ r)) >> (w - 1)) & 1;
                if (word_size && use_imm && o == 5'h04) begin
                    e_fw = 0;
                    e_err = 1;
                end
            end
            5'h06: r = a & b;
            5'h07: r = a | b;
            5'h08: r = a ^ b;
            5'h09: r = ~a;
            5'h0A: begin
                r = a << 1;
                v = ((a >> 7) ^ (a >> 6)) & 1;
            end
            5'h0B: r = a >> 1 | a & 128;
            5'h0C: r = a << 1;
            5'h0D: r = a >> 1;
            5'h0E: r = a << 1 | a >> 7;
            5'h0F: r = a >> 1 | (a & 1) << 7;
            5'h10: r = a << 1 | c;
            5'h11: r = a >> 1 | c << 7;
            default: {e_rw, e_wd, e_fw} = 3'h0;
        endcase
        if (o >= 5'h0A && o <= 5'h11) c = (o % 2 == 0) ? (a >> 7) & 1 : a & 1;
        e_wd = (o == 5'h02 || o == 5'h03);
        if (o < 5'h02 || o > 5'h03 && o < 5'h12) begin
            e_res[7:0] = r[7:0];
            e_fl[3] = (r >> (w - 1)) & 1;
            e_fl[2] = (r & ((1 << w) - 1)) == 0;
            e_fl[0] = c;
            if (o > 5'h01) e_fl[1] = v;
        end
    endtask : model
    // f[0] retries start while dividing, f[1] zero divisor, f[2] word compare with immediate
    task automatic run(input logic [4:0] o, input logic [2:0] f);
        int k;
        @(posedge clk);
        #1;
        op = bamds_op_t'(o);
        start = 1;
        {rd_val, rs_val, imm_val, flags_in} = 48'({$random(seed), $random(seed)});
        {use_imm, word_size} = 2'($random(seed));
        if (f[0]) rs_val[0] = 1;
        if (f[1]) rs_val[7:0] = 8'h00;
        if (f[2]) {use_imm, word_size} = 2'h3;
        if (o == 5'h03 && rd_val[15:8] >= rs_val[7:0]) rd_val[15:8] = 8'h00;
        model(o);
        @(posedge clk);
        #1;
        start = f[0];
        op = BAMDS_OP_NOT;
        for (k = 0; k < 14 && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            start = 0;
        end
        if (done !== 1'b1) begin
            num_errors++;
            $display("MISMATCH done expected 1 seen %b", done);
            end_of_test();
        end
        check("result_wr", 16'(result_wr), 16'(e_rw));
        check("flags_wr", 16'(flags_wr), 16'(e_fw));
        check("op_error", 16'(op_error), 16'(e_err));
        if (e_rw) check("result", result, e_res);
        if (e_rw) check("result_word", 16'(result_word), 16'(e_wd));
        if (e_fw) check("flags", {8'h00, condition_flags & fm}, {8'h00, e_fl & fm});
    endtask : run
    initial begin
        {start, word_size, use_imm, rd_val, rs_val, imm_val, flags_in} = '0;
        op = BAMDS_OP_AND;
        rst = 1;
        repeat (10) @(posedge clk);
        #1;
        rst = 0;
        check("reset result", result, 16'h0000);
        check("reset flags", {8'h00, condition_flags}, 16'h0000);
        for (int i = 0; i < 540; i++) run(5'(i % 18), 3'h0);
        run(5'h04, 3'h4);
        run(5'h03, 3'h2);
        run(5'h03, 3'h1);
        run(5'h1F, 3'h0);
        end_of_test();
    end
endmodule : tb_byte_alu_mul_div_shift

// >>> verilog/bamds_alu.sv
`timescale 1ns/1ps
`include "bamds_params.svh"
//Contract
// RULE1 - Decimal adjust add/sub result using flags
// RULE2 - Unsigned 8x8 multiply, 16-bit product written
// RULE3 - Unsigned 16/8 divide: quotient and remainder
// RULE4 - Quotient low byte, remainder high byte
// RULE5 - Compare updates flags only, byte or word
// RULE6 - Word compare only register to register
// RULE7 - Negate: zero minus register byte
// RULE8 - Byte AND with register or immediate
// RULE9 - Byte OR with register or immediate
// RULE10 - Byte XOR with register or immediate
// RULE11 - Byte invert gives one's complement
// RULE12 - Arithmetic shifts; right keeps sign bit
// RULE13 - Logical shifts fill vacated bit zero
// RULE14 - Rotates wrap outgoing bit to other end
// RULE15 - Rotate through carry flag both ways
// RULE16 - One-bit moves; bit out goes to carry

module bamds_alu (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Request from decoder
    input  wire logic               start,
    input  wire bamds_pkg::bamds_op_t op,
    input  wire logic               word_size,
    input  wire logic               use_imm,
    input  wire logic [15:0]        rd_val,
    input  wire logic [15:0]        rs_val,
    input  wire logic [7:0]         imm_val,
    input  wire logic [7:0]         flags_in,
    // Answer to register file and condition flags
    output logic [15:0]             result,
    output logic                    result_wr,
    output logic                    result_word,
    output logic [7:0]              condition_flags,
    output logic                    flags_wr,
    output logic                    op_error,
    output logic                    busy,
    output logic                    done
);
    import bamds_pkg::*;

    bamds_state_t state_reg;
    logic [7:0]   a;
    logic [7:0]   b;
    logic [7:0]   res8;
    logic [7:0]   fl;
    logic         wr;
    logic         illegal;
    logic [8:0]   sub9;
    logic [4:0]   subh;
    logic [16:0]  sub17;
    logic [7:0]   adj;
    logic         adj_c;
    logic         div_done;
    logic [7:0]   div_q;
    logic [7:0]   div_r;
    logic [7:0]   div_fl_reg;
    logic         div_start;

    assign a         = rd_val[7:0];
    assign b         = use_imm ? imm_val : rs_val[7:0];
    assign div_start = start && state_reg == BAMDS_ST_IDLE && op == BAMDS_OP_UNSIGNED_DIVIDE
                       && rs_val[7:0] != 8'h00;

    bamds_divider u_div (
        .clk       (clk),
        .rst       (rst),
        .start     (div_start),
        .dividend  (rd_val),
        .divisor   (rs_val[7:0]),
        .done      (div_done),
        .quotient  (div_q),
        .remainder (div_r)
    );

    // Shared subtracter for compare and negate
    always_comb begin
        sub9  = (op == BAMDS_OP_TWOS_COMPLEMENT_OP) ? (9'h000 - {1'b0, a}) // RULE7
                                                    : ({1'b0, a} - {1'b0, b});
        subh  = (op == BAMDS_OP_TWOS_COMPLEMENT_OP) ? (5'h00 - {1'b0, a[3:0]})
                                                    : ({1'b0, a[3:0]} - {1'b0, b[3:0]});
        sub17 = {1'b0, rd_val} - {1'b0, rs_val};
    end

    // Decimal correction, driven by incoming H and C
    always_comb begin
        adj   = 8'h00;
        adj_c = flags_in[`BAMDS_FLAG_C];
        if (op == BAMDS_OP_DECIMAL_ADJUST_ADD) begin
            if (flags_in[`BAMDS_FLAG_H] || a[3:0] > `BAMDS_BCD_LIMIT) begin // RULE1
                adj = adj + `BAMDS_BCD_LO_ADJ;
            end
            if (flags_in[`BAMDS_FLAG_C] || a > `BAMDS_BCD_MAX) begin // RULE1
                adj   = adj + `BAMDS_BCD_HI_ADJ;
                adj_c = 1'b1;
            end
        end else begin
            if (flags_in[`BAMDS_FLAG_H]) begin // RULE1
                adj = adj - `BAMDS_BCD_LO_ADJ;
            end
            if (flags_in[`BAMDS_FLAG_C]) begin // RULE1
                adj = adj - `BAMDS_BCD_HI_ADJ;
            end
        end
    end

    // Byte result and flags; untouched flag bits pass through
    always_comb begin
        res8    = a;
        fl      = flags_in;
        wr      = 1'b1;
        illegal = 1'b0;
        case (op)
            BAMDS_OP_DECIMAL_ADJUST_ADD, BAMDS_OP_DECIMAL_ADJUST_SUB: begin
                res8                 = a + adj; // RULE1
                fl[`BAMDS_FLAG_C]    = adj_c;
            end
            BAMDS_OP_COMPARE_OP: begin
                wr = 1'b0; // RULE5
                if (word_size && use_imm) begin
                    illegal = 1'b1; // RULE6
                end else if (word_size) begin
                    fl[`BAMDS_FLAG_C] = sub17[16]; // RULE5
                    fl[`BAMDS_FLAG_N] = sub17[15];
                    fl[`BAMDS_FLAG_Z] = sub17[15:0] == 16'h0000;
                    fl[`BAMDS_FLAG_V] = (rd_val[15] ^ rs_val[15]) & (rd_val[15] ^ sub17[15]);
                    fl[`BAMDS_FLAG_H] = rd_val[11:0] < rs_val[11:0];
                end else begin
                    res8              = sub9[7:0];
                    fl[`BAMDS_FLAG_C] = sub9[8]; // RULE5
                    fl[`BAMDS_FLAG_V] = (a[7] ^ b[7]) & (a[7] ^ sub9[7]);
                    fl[`BAMDS_FLAG_H] = subh[4];
                end
            end
            BAMDS_OP_TWOS_COMPLEMENT_OP: begin
                res8              = sub9[7:0]; // RULE7
                fl[`BAMDS_FLAG_C] = sub9[8];
                fl[`BAMDS_FLAG_V] = a == 8'h80;
                fl[`BAMDS_FLAG_H] = subh[4];
            end
            BAMDS_OP_AND: begin
                res8 = a & b; // RULE8
            end
            BAMDS_OP_OR: begin
                res8 = a | b; // RULE9
            end
            BAMDS_OP_XOR: begin
                res8 = a ^ b; // RULE10
            end
            BAMDS_OP_NOT: begin
                res8 = ~a; // RULE11
            end
            BAMDS_OP_ARITH_SHIFT_LEFT: begin
                res8              = {a[6:0], 1'b0}; // RULE12
                fl[`BAMDS_FLAG_C] = a[7]; // RULE16
            end
            BAMDS_OP_ARITH_SHIFT_RIGHT: begin
                res8              = {a[7], a[7:1]}; // RULE12
                fl[`BAMDS_FLAG_C] = a[0]; // RULE16
            end
            BAMDS_OP_LOGIC_SHIFT_LEFT: begin
                res8              = {a[6:0], 1'b0}; // RULE13
                fl[`BAMDS_FLAG_C] = a[7]; // RULE16
            end
            BAMDS_OP_LOGIC_SHIFT_RIGHT: begin
                res8              = {1'b0, a[7:1]}; // RULE13
                fl[`BAMDS_FLAG_C] = a[0]; // RULE16
            end
            BAMDS_OP_ROTATE_LEFT: begin
                res8              = {a[6:0], a[7]}; // RULE14
                fl[`BAMDS_FLAG_C] = a[7]; // RULE16
            end
            BAMDS_OP_ROTATE_RIGHT: begin
                res8              = {a[0], a[7:1]}; // RULE14
                fl[`BAMDS_FLAG_C] = a[0]; // RULE16
            end
            BAMDS_OP_ROTATE_LEFT_CARRY: begin
                res8              = {a[6:0], flags_in[`BAMDS_FLAG_C]}; // RULE15
                fl[`BAMDS_FLAG_C] = a[7]; // RULE16
            end
            BAMDS_OP_ROTATE_RIGHT_CARRY: begin
                res8              = {flags_in[`BAMDS_FLAG_C], a[7:1]}; // RULE15
                fl[`BAMDS_FLAG_C] = a[0]; // RULE16
            end
            default: begin
                wr = 1'b0;
            end
        endcase
        // Byte-wide N and Z, skipped when the word compare has set them
        if (!(op == BAMDS_OP_COMPARE_OP && word_size)) begin
            fl[`BAMDS_FLAG_N] = res8[7];
            fl[`BAMDS_FLAG_Z] = res8 == 8'h00;
        end
        // Logic and shift ops clear V; arithmetic left reports sign change
        if (op >= BAMDS_OP_AND && op <= BAMDS_OP_ROTATE_RIGHT_CARRY) begin
            fl[`BAMDS_FLAG_V] = (op == BAMDS_OP_ARITH_SHIFT_LEFT) ? (a[7] ^ a[6]) : 1'b0;
        end
    end

    // Sequencing: one cycle for most ops, divide waits on the iterator
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= BAMDS_ST_IDLE;
        end else if (div_start) begin
            state_reg <= BAMDS_ST_DIV;
        end else if (div_done) begin
            state_reg <= BAMDS_ST_IDLE;
        end
    end

    // Divide flags are fixed at launch so the late result uses them
    always_ff @(posedge clk) begin
        if (rst) begin
            div_fl_reg <= `BAMDS_FLAGS_RST;
        end else if (div_start) begin
            div_fl_reg <= flags_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            result          <= `BAMDS_RESULT_RST;
            result_wr       <= 1'b0;
            result_word     <= 1'b0;
            condition_flags <= `BAMDS_FLAGS_RST;
            flags_wr        <= 1'b0;
            op_error        <= 1'b0;
            done            <= 1'b0;
        end else begin
            result_wr   <= 1'b0;
            result_word <= 1'b0;
            flags_wr    <= 1'b0;
            op_error    <= 1'b0;
            done        <= 1'b0;
            if (div_done) begin
                result          <= {div_r, div_q}; // RULE3 RULE4
                result_wr       <= 1'b1;
                result_word     <= 1'b1;
                condition_flags <= {div_fl_reg[7:4], div_q[7], 1'b0, div_fl_reg[1:0]};
                flags_wr        <= 1'b1;
                done            <= 1'b1;
            end else if (start && state_reg == BAMDS_ST_IDLE) begin
                done <= 1'b1;
                case (op)
                    BAMDS_OP_UNSIGNED_MULTIPLY: begin
                        result      <= {8'h00, a} * {8'h00, rs_val[7:0]}; // RULE2
                        result_wr   <= 1'b1;
                        result_word <= 1'b1;
                    end
                    BAMDS_OP_UNSIGNED_DIVIDE: begin
                        // Zero divisor: no write, Z raised; otherwise wait for iterator
                        done <= 1'b0;
                        if (rs_val[7:0] == 8'h00) begin
                            condition_flags <= flags_in | (8'h01 << `BAMDS_FLAG_Z);
                            flags_wr        <= 1'b1;
                            done            <= 1'b1;
                        end
                    end
                    default: begin
                        // Undefined codes only finish; flags must not pick up garbage
                        if (illegal) begin
                            op_error <= 1'b1; // RULE6
                        end else if (wr || op == BAMDS_OP_COMPARE_OP) begin
                            result          <= {rd_val[15:8], res8};
                            result_wr       <= wr;
                            condition_flags <= fl;
                            flags_wr        <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Busy mirrors the divide state so the decoder holds further requests
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= div_start || (state_reg == BAMDS_ST_DIV && !div_done);
        end
    end
endmodule : bamds_alu

// >>> verilog/bamds_divider.sv
`timescale 1ns/1ps
`include "bamds_params.svh"

module bamds_divider (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Request
    input  wire logic        start,
    input  wire logic [15:0] dividend,
    input  wire logic [7:0]  divisor,
    // Answer
    output logic             done,
    output logic [7:0]       quotient,
    output logic [7:0]       remainder
);
    logic [3:0] count_reg;
    logic [8:0] rem_reg;
    logic [7:0] quo_reg;
    logic [7:0] div_reg;
    logic       run_reg;
    logic [8:0] trial;
    logic [8:0] diff;

    // Restoring divide; a 9-bit partial remainder tolerates a top bit carried out
    assign trial = {rem_reg[7:0], quo_reg[7]};
    assign diff  = trial - {1'b0, div_reg};

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= 4'h0;
            rem_reg   <= 9'h000;
            quo_reg   <= 8'h00;
            div_reg   <= 8'h00;
            run_reg   <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_reg   <= {1'b0, dividend[15:8]};
                quo_reg   <= dividend[7:0];
                div_reg   <= divisor;
                count_reg <= `BAMDS_DIV_STEPS;
                run_reg   <= 1'b1;
            end else if (run_reg) begin
                if (rem_reg[8] || !diff[8]) begin
                    rem_reg <= {1'b0, rem_reg[8] ? (trial[7:0] - div_reg) : diff[7:0]};
                    quo_reg <= {quo_reg[6:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    quo_reg <= {quo_reg[6:0], 1'b0};
                end
                count_reg <= count_reg - 4'h1;
                if (count_reg == 4'h1) begin
                    run_reg <= 1'b0;
                    done    <= 1'b1;
                end
            end
        end
    end

    assign quotient  = quo_reg;
    assign remainder = rem_reg[7:0];
endmodule : bamds_divider
